// [rtl/rtcbr_pkg.sv]
// Package: constants for the two-wire slave recovery block
package rtcbr_pkg;
  localparam int          CLK_HZ           = 40_000_000;
  localparam int          HALF_HZ_NS       = 500_000_000;
  localparam int          CLK_PERIOD_NS    = 25;
  localparam int          HALF_PERIOD_CYC  = HALF_HZ_NS / CLK_PERIOD_NS;
  localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h30;
  localparam logic [3:0]  BIT_CNT_RESET    = 4'h0;
  // One below zero: the fall that closes a start is not a bit
  localparam logic [3:0]  BIT_CNT_START    = 4'hf;
  localparam logic [3:0]  BIT_ACK_SLOT     = 4'h8;
  localparam logic [7:0]  READ_DATA_RESET  = 8'h00;
  localparam logic [1:0]  SYNC_RESET       = 2'h3;
  typedef enum logic [2:0] {
    RTCBR_IDLE,
    RTCBR_ADDR,
    RTCBR_ADDR_ACK,
    RTCBR_WRITE,
    RTCBR_WRITE_ACK,
    RTCBR_READ,
    RTCBR_READ_ACK,
    RTCBR_IGNORE
  } rtcbr_state_t;
endpackage : rtcbr_pkg

// [rtl/rtcbr_sync.sv]
// Two-stage synchroniser with edge and level outputs
`timescale 1ns/10ps
module rtcbr_sync (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic [1:0] sync_ff;
  logic       last_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      sync_ff <= rtcbr_pkg::SYNC_RESET;
      last_ff <= 1'b1;
    end else begin
      sync_ff <= {sync_ff[0], async_in};
      last_ff <= sync_ff[1];
    end
  end

  assign level = sync_ff[1];
  assign rise  = sync_ff[1] & ~last_ff;
  assign fall  = ~sync_ff[1] & last_ff;
endmodule : rtcbr_sync

// [rtl/rtcbr_slave.sv]
// Two-wire slave interface with stop-based reset and recovery behaviour
// Function
// - A broken-off transfer keeps interface state; nothing new happens until recovered.
// - No reset pin; a stop condition returns the interface to idle.
// - While the device pulls SDA low, a stop condition is ignored.
// - Recovery clocks finish the pending slot, release SDA; then stop resets.
// - A write acknowledged during recovery may still be committed.
// - At power-up the first interrupt pin outputs a 1 Hz square wave.
// - Device pulls SDA low as acknowledge on the ninth clock of each matching address byte and each write byte.
`timescale 1ns/10ps
module rtcbr_slave (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [6:0] dev_addr,
  input  wire logic [7:0] read_data,
  input  wire logic       init_done,
  output logic [7:0]      write_data,
  output logic            write_strobe,
  output logic            read_strobe,
  output logic            busy,
  output logic            interrupt_out_first_n
);
  // ====================================================================
  // Pin synchronisers
  logic scl_lvl, scl_rise, scl_fall;
  logic sda_lvl, sda_rise, sda_fall;

  rtcbr_sync u_scl_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (scl_in),
    .level    (scl_lvl),
    .rise     (scl_rise),
    .fall     (scl_fall)
  );

  rtcbr_sync u_sda_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (sda_in),
    .level    (sda_lvl),
    .rise     (sda_rise),
    .fall     (sda_fall)
  );

  // ====================================================================
  // Bus conditions
  logic start_seen;
  logic stop_seen;
  logic driving_low;
  logic sda_out_ff;
  logic sda_oe_ff;

  assign driving_low = sda_oe_ff & ~sda_out_ff;
  // Own low drive masks the line, so a start cannot be seen then either
  assign start_seen  = sda_fall & scl_lvl & ~driving_low;
  assign stop_seen   = sda_rise & scl_lvl & ~driving_low;

  // ====================================================================
  // Interface state machine
  rtcbr_pkg::rtcbr_state_t state_ff;
  rtcbr_pkg::rtcbr_state_t nxt_state;
  logic [3:0]              bit_cnt_ff;
  logic [7:0]              shift_ff;
  logic                    rd_mode_ff;
  logic                    master_nack_ff;

  function automatic logic is_byte_done(input logic [3:0] cnt);
    return cnt == 4'h7;
  endfunction : is_byte_done

  always_comb begin
    nxt_state = state_ff;
    if (stop_seen) begin
      nxt_state = rtcbr_pkg::RTCBR_IDLE;
    end else if (start_seen) begin
      nxt_state = rtcbr_pkg::RTCBR_ADDR;
    end else if (scl_fall) begin
      unique case (state_ff)
        rtcbr_pkg::RTCBR_IDLE:      nxt_state = rtcbr_pkg::RTCBR_IDLE;
        rtcbr_pkg::RTCBR_IGNORE:    nxt_state = rtcbr_pkg::RTCBR_IGNORE;
        rtcbr_pkg::RTCBR_ADDR: begin
          if (is_byte_done(bit_cnt_ff)) begin
            nxt_state = (shift_ff[7:1] == dev_addr) ? rtcbr_pkg::RTCBR_ADDR_ACK : rtcbr_pkg::RTCBR_IGNORE;
          end
        end
        rtcbr_pkg::RTCBR_ADDR_ACK:  nxt_state = rd_mode_ff ? rtcbr_pkg::RTCBR_READ : rtcbr_pkg::RTCBR_WRITE;
        rtcbr_pkg::RTCBR_WRITE: begin
          if (is_byte_done(bit_cnt_ff)) begin
            nxt_state = rtcbr_pkg::RTCBR_WRITE_ACK;
          end
        end
        rtcbr_pkg::RTCBR_WRITE_ACK: nxt_state = rtcbr_pkg::RTCBR_WRITE;
        rtcbr_pkg::RTCBR_READ: begin
          if (is_byte_done(bit_cnt_ff)) begin
            nxt_state = rtcbr_pkg::RTCBR_READ_ACK;
          end
        end
        rtcbr_pkg::RTCBR_READ_ACK:  nxt_state = master_nack_ff ? rtcbr_pkg::RTCBR_IGNORE : rtcbr_pkg::RTCBR_READ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= rtcbr_pkg::RTCBR_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Bit counter advances per SCL fall inside a byte
  always_ff @(posedge clock) begin
    if (rst || stop_seen) begin
      bit_cnt_ff <= rtcbr_pkg::BIT_CNT_RESET;
    end else if (start_seen) begin
      bit_cnt_ff <= rtcbr_pkg::BIT_CNT_START;
    end else if (scl_fall) begin
      if (state_ff inside {rtcbr_pkg::RTCBR_ADDR_ACK, rtcbr_pkg::RTCBR_WRITE_ACK, rtcbr_pkg::RTCBR_READ_ACK}
          || is_byte_done(bit_cnt_ff)) begin
        bit_cnt_ff <= rtcbr_pkg::BIT_CNT_RESET;
      end else begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
    end
  end

  // Receive shifter and master acknowledge capture on SCL rise
  always_ff @(posedge clock) begin
    if (rst) begin
      shift_ff       <= rtcbr_pkg::READ_DATA_RESET;
      rd_mode_ff     <= 1'b0;
      master_nack_ff <= 1'b0;
    end else if (scl_rise) begin
      if (state_ff inside {rtcbr_pkg::RTCBR_ADDR, rtcbr_pkg::RTCBR_WRITE}) begin
        shift_ff <= {shift_ff[6:0], sda_lvl};
      end
      if (state_ff == rtcbr_pkg::RTCBR_ADDR && is_byte_done(bit_cnt_ff)) begin
        rd_mode_ff <= sda_lvl;
      end
      if (state_ff == rtcbr_pkg::RTCBR_READ_ACK) begin
        master_nack_ff <= sda_lvl;
      end
    end
  end

  // ====================================================================
  // SDA drive: ack on ninth clock, read bits from MSB
  logic [7:0] tx_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      sda_out_ff <= 1'b1;
      sda_oe_ff  <= 1'b0;
      tx_ff      <= rtcbr_pkg::READ_DATA_RESET;
    end else if (stop_seen || start_seen) begin
      sda_out_ff <= 1'b1;
      sda_oe_ff  <= 1'b0;
    end else if (scl_fall) begin
      unique case (nxt_state)
        rtcbr_pkg::RTCBR_ADDR_ACK, rtcbr_pkg::RTCBR_WRITE_ACK: begin
          sda_out_ff <= 1'b0;
          sda_oe_ff  <= 1'b1;
        end
        rtcbr_pkg::RTCBR_READ: begin
          if (state_ff != rtcbr_pkg::RTCBR_READ) begin
            tx_ff      <= {read_data[6:0], 1'b0};
            sda_out_ff <= read_data[7];
          end else begin
            tx_ff      <= {tx_ff[6:0], 1'b0};
            sda_out_ff <= tx_ff[7];
          end
          sda_oe_ff <= 1'b1;
        end
        default: begin
          sda_out_ff <= 1'b1;
          sda_oe_ff  <= 1'b0;
        end
      endcase
    end
  end

  // ====================================================================
  // User-side strobes and status
  always_ff @(posedge clock) begin
    if (rst) begin
      write_data   <= rtcbr_pkg::READ_DATA_RESET;
      write_strobe <= 1'b0;
      read_strobe  <= 1'b0;
      busy         <= 1'b0;
    end else begin
      // Commit even when the acked byte was cut off by recovery
      write_strobe <= scl_fall && state_ff == rtcbr_pkg::RTCBR_WRITE
                      && nxt_state == rtcbr_pkg::RTCBR_WRITE_ACK;
      read_strobe  <= scl_fall && nxt_state == rtcbr_pkg::RTCBR_READ
                      && state_ff != rtcbr_pkg::RTCBR_READ;
      if (scl_fall && state_ff == rtcbr_pkg::RTCBR_WRITE && is_byte_done(bit_cnt_ff)) begin
        write_data <= shift_ff;
      end
      busy <= nxt_state != rtcbr_pkg::RTCBR_IDLE;
    end
  end

  assign sda_out = sda_out_ff;
  assign sda_oe  = sda_oe_ff;

  // ====================================================================
  // Power-on 1 Hz output, low-active pin
  logic [$clog2(rtcbr_pkg::HALF_PERIOD_CYC)-1:0] half_cnt_ff;
  logic                                           pon_active_ff;
  logic                                           sq_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      half_cnt_ff           <= '0;
      pon_active_ff         <= 1'b1;
      sq_ff                 <= 1'b0;
      interrupt_out_first_n <= 1'b1;
    end else begin
      if (init_done) begin
        pon_active_ff <= 1'b0;
      end
      if (half_cnt_ff == ($clog2(rtcbr_pkg::HALF_PERIOD_CYC))'(rtcbr_pkg::HALF_PERIOD_CYC - 1)) begin
        half_cnt_ff <= '0;
        sq_ff       <= ~sq_ff;
      end else begin
        half_cnt_ff <= half_cnt_ff + 1'b1;
      end
      interrupt_out_first_n <= pon_active_ff ? ~sq_ff : 1'b1;
    end
  end
endmodule : rtcbr_slave

// [dv/rtcbr_slave_monitor.sv]
// Assertion checker for the two-wire slave recovery block
`timescale 1ns/10ps
module rtcbr_slave_monitor (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [6:0] dev_addr,
  input wire logic [7:0] read_data,
  input wire logic       init_done,
  input wire logic [7:0] write_data,
  input wire logic       write_strobe,
  input wire logic       read_strobe,
  input wire logic       busy,
  input wire logic       interrupt_out_first_n
);
  logic dev_low;
  assign dev_low = sda_oe && !sda_out;
  default clocking mon_cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence low_under_high_scl;
    (scl_in && dev_low) [*5];
  endsequence
  sequence stop_on_pins;
    scl_in && $rose(sda_in) && !dev_low;
  endsequence
  chk_reset_clears: assert property (disable iff (1'b0) rst |=> !sda_oe && !busy && !write_strobe)
    else $error("Outputs not cleared by reset");
  chk_stop_to_idle: assert property (stop_on_pins |-> ##[1:8] !busy)
    else $error("Stop did not return interface to idle");
  chk_low_holds: assert property (low_under_high_scl |=> dev_low)
    else $error("Low drive dropped without a clock fall");
  chk_low_busy: assert property (dev_low |-> busy)
    else $error("Pulling low while idle");
  chk_drive_on_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("Drive started outside a low clock phase");
  chk_wstrobe_pulse: assert property (write_strobe |-> !scl_in ##1 !write_strobe)
    else $error("Write strobe misplaced or too long");
  chk_rstrobe_pulse: assert property (read_strobe |-> busy && !scl_in ##1 !read_strobe)
    else $error("Read strobe misplaced or too long");
  chk_int_stopped: assert property (init_done && $past(init_done, 3) |-> interrupt_out_first_n)
    else $error("Power-on square wave not stopped");
endmodule : rtcbr_slave_monitor

bind rtcbr_slave rtcbr_slave_monitor rtcbr_slave_monitor_inst (.clock(clock), .rst(rst), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .dev_addr(dev_addr), .read_data(read_data),
  .init_done(init_done), .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
  .busy(busy), .interrupt_out_first_n(interrupt_out_first_n));

// [dv/rtcbr_master.sv]
// Two-wire bus master model: start, bits, stop and recovery
`timescale 1ns/10ps
module rtcbr_master #(
  parameter int PH = 4
) (
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic pause(input int n);
    repeat (n) @(negedge clock);
  endtask : pause
  task automatic start();
    sda_low = 1'b0;
    pause(PH);
    scl = 1'b1;
    pause(PH);
    sda_low = 1'b1;
    pause(PH);
    scl = 1'b0;
  endtask : start
  task automatic xfer_bit(input logic b, output logic r);
    pause(PH / 2);
    sda_low = ~b;
    pause(PH / 2);
    scl = 1'b1;
    pause(PH);
    r   = sda;
    scl = 1'b0;
  endtask : xfer_bit
  task automatic xfer_byte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) xfer_bit(d[i], q[i]);
    xfer_bit(1'b1, ack);
  endtask : xfer_byte
  task automatic stop();
    pause(PH / 2);
    sda_low = 1'b1;
    pause(PH / 2);
    scl = 1'b1;
    pause(PH);
    sda_low = 1'b0;
    pause(PH);
  endtask : stop
  task automatic recover(output logic [7:0] first_bits);
    logic r;
    start();
    for (int i = 0; i < 63; i++) begin
      xfer_bit(1'b1, r);
      if (i < 8) first_bits[7 - i] = r;
    end
    stop();
  endtask : recover
endmodule : rtcbr_master

// [dv/tb.sv]
// Self-checking bench: writes, broken read, recovery
`timescale 1ns/10ps
module tb;
  localparam logic [6:0] ADDR = rtcbr_pkg::DEV_ADDR_DEFAULT;
  logic        clock, rst, init_done, sda_out, sda_oe, write_strobe, read_strobe, busy, irq_n, scl, m_low, ack;
  logic        sda;
  logic [7:0]  read_data, write_data, q;
  logic [31:0] seed = 32'hcddb;
  logic [7:0]  exp_q[$];
  int          n_errors = 0;
  int          n_compared = 0;
  assign sda = ~m_low & ~(sda_oe & ~sda_out);
  rtcbr_slave rtcbr_slave_inst (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .dev_addr(ADDR), .read_data(read_data), .init_done(init_done), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .busy(busy), .interrupt_out_first_n(irq_n));
  rtcbr_master rtcbr_master_inst (.clock(clock), .sda(sda), .scl(scl), .sda_low(m_low));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      n_errors++;
      $display("ERROR %0t: seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic finish_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic do_write(input logic [7:0] d);
    rtcbr_master_inst.start();
    rtcbr_master_inst.xfer_byte({ADDR, 1'b0}, q, ack);
    check({7'h0, ack}, 8'h00);
    exp_q.push_back(d);
    rtcbr_master_inst.xfer_byte(d, q, ack);
    check({7'h0, ack}, 8'h00);
    rtcbr_master_inst.stop();
    check({7'h0, busy}, 8'h00);
  endtask : do_write
  always @(negedge clock) begin
    if (write_strobe === 1'b1) begin
      check(write_data, exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx);
    end
  end
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    repeat (6000) @(posedge clock);
    n_errors++;
    finish_test();
  end
  initial begin
    {rst, init_done, read_data} = 10'h200;
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    seed = lfsr(seed);
    do_write(seed[7:0]);
    // Master abandons a read while the device acknowledges
    read_data = seed[15:8];
    q = {ADDR, 1'b1};
    rtcbr_master_inst.start();
    for (int i = 7; i >= 0; i--) rtcbr_master_inst.xfer_bit(q[i], ack);
    rtcbr_master_inst.stop();
    check({7'h0, sda}, 8'h00);
    check({7'h0, busy}, 8'h01);
    rtcbr_master_inst.recover(q);
    check(q, seed[15:8]);
    check({7'h0, busy}, 8'h00);
    seed = lfsr(seed);
    do_write(seed[7:0]);
    init_done = 1'b1;
    repeat (4) @(negedge clock);
    check({7'h0, irq_n}, 8'h01);
    finish_test();
  end
endmodule : tb
